// >>> common/cttbs_pkg.sv
/*
 * Constants, register map and state encoding of the charger timer,
 * compensation and battery switch register slice.
 * Assumes a 50 MHz ref_clk and a host on the two-wire serial bus.
 */
package cttbs_pkg;

    // Register map
    localparam logic [7:0] ADDR_TIMER  = 8'h07;
    localparam logic [7:0] ADDR_COMP   = 8'h08;
    localparam logic [7:0] ADDR_SWITCH = 8'h09;
    localparam logic [7:0] ADDR_BOOST  = 8'h0A;

    // Power-on values
    localparam logic [7:0] POR_TIMER  = 8'h9D;
    localparam logic [7:0] POR_COMP   = 8'h03;
    localparam logic [7:0] POR_SWITCH = 8'h44;
    localparam logic [7:0] POR_BOOST  = 8'h73;

    // Fields restored by watchdog expiry
    localparam logic [7:0] WDM_TIMER  = 8'hFF;
    localparam logic [7:0] WDM_COMP   = 8'hFF;
    localparam logic [7:0] WDM_SWITCH = 8'hD3;
    localparam logic [7:0] WDM_BOOST  = 8'hF7;

    // Timer and termination fields
    localparam int TERM_EN_BIT   = 7;
    localparam int STATUS_PIN_DISABLE_BIT  = 6;
    localparam int WD_LSB        = 4;
    localparam int SAFE_EN_BIT   = 3;
    localparam int SAFE_PER_LSB  = 1;

    // Compensation and thermal fields
    localparam int IRR_LSB       = 5;
    localparam int CLAMP_LSB     = 2;
    localparam int TREG_LSB      = 0;

    // Battery switch and pulse fields
    localparam int HALF_BIT      = 6;
    localparam int SHIP_BIT      = 5;
    localparam int DLY_BIT       = 3;
    localparam int SRST_BIT      = 2;
    localparam int RAISE_BIT     = 1;
    localparam int LOWER_BIT     = 0;

    // Watchdog periods in seconds
    localparam logic [7:0] WD_SEC_01 = 8'h28;
    localparam logic [7:0] WD_SEC_10 = 8'h50;
    localparam logic [7:0] WD_SEC_11 = 8'hA0;

    // Safety timer periods in hours
    localparam int SAFE_HR_00    = 5;
    localparam int SAFE_HR_01    = 8;
    localparam int SAFE_HR_10    = 12;
    localparam int SAFE_HR_11    = 20;
    localparam int SEC_PER_HOUR  = 3600;
    localparam int SAFE_W        = 17;

    // Clock and second tick
    localparam int CLK_PERIOD_NS = 20;
    localparam int SEC_NS        = 1_000_000_000;
    localparam int SEC_CYCLES    = SEC_NS / CLK_PERIOD_NS;

    // Ship mode delay in seconds
    localparam int SHIP_DLY_SEC  = 10;

    // Serial bus target address, arbitrary value
    localparam logic [6:0] BUS_ADDR = 7'h2A;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_AACK = 4'h3,
        ST_PTR  = 4'h2,
        ST_PACK = 4'h6,
        ST_WR   = 4'h7,
        ST_WACK = 4'h5,
        ST_RD   = 4'h4,
        ST_RACK = 4'hC
    } cttbs_state_t;

endpackage : cttbs_pkg

// >>> rtl/cttbs_tick.sv
/*
 * Free-running divider producing a one-cycle tick every CYCLES clocks.
 * Assumes a single clock domain and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
module cttbs_tick
    import cttbs_pkg::*;
#(
    parameter int CYCLES = SEC_CYCLES
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // Tick
    output logic      tick_q
);

    logic [31:0] cnt_q;

    // Divider
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q  <= 32'h0;
            tick_q <= 1'b0;
        end else if (cnt_q == 32'(CYCLES - 1)) begin
            cnt_q  <= 32'h0;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 32'h1;
            tick_q <= 1'b0;
        end
    end

endmodule : cttbs_tick

// >>> rtl/cttbs_regs.sv
/*
 * Timer, compensation, battery switch and boost control registers with
 * their two-wire serial target, watchdog, safety timer and ship mode delay.
 * Assumes scl_in and sda_in already synchronous to ref_clk; the sda wire is
 * resolved outside from sda_oe_q.
 */
`timescale 1ns/100ps

module cttbs_regs
    import cttbs_pkg::*;
#(
    parameter int         SEC_CYC  = SEC_CYCLES,
    parameter int         SHIP_DLY = SHIP_DLY_SEC,
    parameter logic [6:0] DEV_ADDR = BUS_ADDR
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // Serial bus
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out_q,
    output logic            sda_oe_q,
    // Charger status inputs
    input  wire logic       soft_reg_reset,
    input  wire logic       watchdog_kick,
    input  wire logic       charging_active,
    input  wire logic       regulation_active,
    input  wire logic       pulse_control_enable,
    input  wire logic       pulse_sequence_done,
    // Control outputs
    output logic            charge_term_enable_q,
    output logic            status_pin_disable_q,
    output logic            safety_timer_enable_q,
    output logic [1:0]      safety_period_select_q,
    output logic [2:0]      ir_comp_resistance_q,
    output logic [2:0]      ir_comp_clamp_q,
    output logic [1:0]      thermal_threshold_select_q,
    output logic            timer_half_speed_enable_q,
    output logic            system_reset_enable_q,
    output logic            pulse_raise_request_q,
    output logic            pulse_lower_request_q,
    output logic [7:0]      boost_control_q,
    // Timer and switch outputs
    output logic            battery_switch_off_q,
    output logic            watchdog_expired_q,
    output logic            safety_timer_expired_q
);

    logic [7:0]   timer_q;
    logic [7:0]   comp_q;
    logic [7:0]   switch_q;
    logic [7:0]   boost_q;
    logic         sec_tick;
    logic         scl_prev_q;
    logic         sda_prev_q;
    cttbs_state_t state_q;
    logic [3:0]   bit_cnt_q;
    logic [7:0]   shift_q;
    logic [7:0]   ptr_q;
    logic         rw_q;
    logic         mack_q;
    logic         wr_en_q;
    logic [7:0]   wr_addr_q;
    logic [7:0]   wr_data_q;
    logic [7:0]   rd_byte;
    logic         start_det;
    logic         stop_det;
    logic         scl_rise;
    logic         scl_fall;
    logic [7:0]   wd_cnt_q;
    logic [7:0]   wd_limit;
    logic [SAFE_W-1:0] safe_cnt_q;
    logic         half_q;
    logic [31:0]  ship_cnt_q;
    logic [1:0]   pulse_wr;

    function automatic logic [7:0] restore(input logic [7:0] cur,
                                           input logic [7:0] por,
                                           input logic [7:0] mask);
        restore = (cur & ~mask) | (por & mask);
    endfunction : restore

    function automatic logic [7:0] read_reg(input logic [7:0] a,
                                            input logic [7:0] r7,
                                            input logic [7:0] r8,
                                            input logic [7:0] r9,
                                            input logic [7:0] ra);
        unique case (a)
            ADDR_TIMER:  read_reg = r7;
            ADDR_COMP:   read_reg = r8;
            ADDR_SWITCH: read_reg = r9;
            ADDR_BOOST:  read_reg = ra;
            default:     read_reg = 8'h00;
        endcase
    endfunction : read_reg

    function automatic logic [SAFE_W-1:0] safe_limit(input logic [1:0] code);
        unique case (code)
            2'b00: safe_limit = SAFE_W'(SAFE_HR_00 * SEC_PER_HOUR);
            2'b01: safe_limit = SAFE_W'(SAFE_HR_01 * SEC_PER_HOUR);
            2'b10: safe_limit = SAFE_W'(SAFE_HR_10 * SEC_PER_HOUR);
            2'b11: safe_limit = SAFE_W'(SAFE_HR_11 * SEC_PER_HOUR);
        endcase
    endfunction : safe_limit

    cttbs_tick #(
        .CYCLES (SEC_CYC)
    ) u_tick (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .tick_q  (sec_tick)
    );

    assign start_det = scl_in && scl_prev_q && sda_prev_q && !sda_in;
    assign stop_det  = scl_in && scl_prev_q && !sda_prev_q && sda_in;
    assign scl_rise  = scl_in && !scl_prev_q;
    assign scl_fall  = !scl_in && scl_prev_q;
    assign rd_byte   = read_reg(ptr_q, timer_q, comp_q, switch_q, boost_q);

    // Field outputs
    assign charge_term_enable_q       = timer_q[TERM_EN_BIT];
    assign status_pin_disable_q       = timer_q[STATUS_PIN_DISABLE_BIT];
    assign safety_timer_enable_q      = timer_q[SAFE_EN_BIT];
    assign safety_period_select_q     = timer_q[SAFE_PER_LSB +: 2];
    assign ir_comp_resistance_q       = comp_q[IRR_LSB +: 3];
    assign ir_comp_clamp_q            = comp_q[CLAMP_LSB +: 3];
    assign thermal_threshold_select_q = comp_q[TREG_LSB +: 2];
    assign timer_half_speed_enable_q  = switch_q[HALF_BIT];
    assign system_reset_enable_q      = switch_q[SRST_BIT];
    assign pulse_raise_request_q      = switch_q[RAISE_BIT];
    assign pulse_lower_request_q      = switch_q[LOWER_BIT];
    assign boost_control_q            = boost_q;

    // Line sampling
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            sda_out_q  <= 1'b0;
        end else begin
            scl_prev_q <= scl_in;
            sda_prev_q <= sda_in;
            sda_out_q  <= 1'b0;
        end
    end

    // Serial target
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            ptr_q     <= 8'h00;
            rw_q      <= 1'b0;
            mack_q    <= 1'b0;
            sda_oe_q  <= 1'b0;
            wr_en_q   <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
        end else begin
            wr_en_q <= 1'b0;
            if (start_det) begin
                state_q   <= ST_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe_q  <= 1'b0;
            end else if (stop_det) begin
                state_q  <= ST_IDLE;
                sda_oe_q <= 1'b0;
            end else if (scl_rise) begin
                unique case (state_q)
                    ST_ADDR, ST_PTR, ST_WR: begin
                        shift_q   <= {shift_q[6:0], sda_in};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    ST_RD: begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    ST_RACK: begin
                        mack_q <= !sda_in;
                    end
                    ST_IDLE, ST_AACK, ST_PACK, ST_WACK: begin
                    end
                endcase
            end else if (scl_fall) begin
                unique case (state_q)
                    ST_ADDR: begin
                        if (bit_cnt_q == 4'h8) begin
                            bit_cnt_q <= 4'h0;
                            if (shift_q[7:1] == DEV_ADDR) begin
                                state_q  <= ST_AACK;
                                rw_q     <= shift_q[0];
                                sda_oe_q <= 1'b1;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        bit_cnt_q <= 4'h0;
                        if (rw_q) begin
                            state_q  <= ST_RD;
                            shift_q  <= rd_byte;
                            sda_oe_q <= !rd_byte[7];
                            ptr_q    <= ptr_q + 8'h01;
                        end else begin
                            state_q  <= ST_PTR;
                            sda_oe_q <= 1'b0;
                        end
                    end
                    ST_PTR: begin
                        if (bit_cnt_q == 4'h8) begin
                            state_q  <= ST_PACK;
                            ptr_q    <= shift_q;
                            sda_oe_q <= 1'b1;
                        end
                    end
                    ST_PACK, ST_WACK: begin
                        state_q   <= ST_WR;
                        bit_cnt_q <= 4'h0;
                        sda_oe_q  <= 1'b0;
                    end
                    ST_WR: begin
                        if (bit_cnt_q == 4'h8) begin
                            state_q   <= ST_WACK;
                            sda_oe_q  <= 1'b1;
                            wr_en_q   <= 1'b1;
                            wr_addr_q <= ptr_q;
                            wr_data_q <= shift_q;
                            ptr_q     <= ptr_q + 8'h01;
                        end
                    end
                    ST_RD: begin
                        if (bit_cnt_q == 4'h8) begin
                            state_q  <= ST_RACK;
                            sda_oe_q <= 1'b0;
                        end else begin
                            shift_q  <= {shift_q[6:0], 1'b0};
                            sda_oe_q <= !shift_q[6];
                        end
                    end
                    ST_RACK: begin
                        if (mack_q) begin
                            state_q   <= ST_RD;
                            bit_cnt_q <= 4'h0;
                            shift_q   <= rd_byte;
                            sda_oe_q  <= !rd_byte[7];
                            ptr_q     <= ptr_q + 8'h01;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                    ST_IDLE: begin
                    end
                endcase
            end
        end
    end

    // Pulse request bits take a 1 only while enabled
    assign pulse_wr = wr_data_q[1:0] & ({2{pulse_control_enable}} | switch_q[1:0]);

    // Register file
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            timer_q  <= POR_TIMER;
            comp_q   <= POR_COMP;
            switch_q <= POR_SWITCH;
            boost_q  <= POR_BOOST;
        end else if (soft_reg_reset) begin
            timer_q  <= POR_TIMER;
            comp_q   <= POR_COMP;
            switch_q <= POR_SWITCH;
            boost_q  <= POR_BOOST;
        end else if (watchdog_expired_q) begin
            timer_q  <= restore(timer_q, POR_TIMER, WDM_TIMER);
            comp_q   <= restore(comp_q, POR_COMP, WDM_COMP);
            switch_q <= restore(switch_q, POR_SWITCH, WDM_SWITCH);
            boost_q  <= restore(boost_q, POR_BOOST, WDM_BOOST);
        end else if (wr_en_q) begin
            unique case (wr_addr_q)
                ADDR_TIMER:  timer_q <= wr_data_q;
                ADDR_COMP:   comp_q  <= wr_data_q;
                ADDR_SWITCH: switch_q <= {wr_data_q[7:2], pulse_wr};
                ADDR_BOOST:  boost_q <= wr_data_q;
                default: begin
                end
            endcase
        end else if (pulse_sequence_done) begin
            switch_q[1:0] <= 2'b00;
        end
    end

    // Watchdog period
    always_comb begin
        unique case (timer_q[WD_LSB +: 2])
            2'b00: wd_limit = 8'h00;
            2'b01: wd_limit = WD_SEC_01;
            2'b10: wd_limit = WD_SEC_10;
            2'b11: wd_limit = WD_SEC_11;
        endcase
    end

    // Watchdog counter, restarted by any register write or a kick
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wd_cnt_q           <= 8'h00;
            watchdog_expired_q <= 1'b0;
        end else begin
            watchdog_expired_q <= 1'b0;
            if (wd_limit == 8'h00 || wr_en_q || watchdog_kick || soft_reg_reset) begin
                wd_cnt_q <= 8'h00;
            end else if (sec_tick) begin
                if (wd_cnt_q + 8'h01 >= wd_limit) begin
                    wd_cnt_q           <= 8'h00;
                    watchdog_expired_q <= 1'b1;
                end else begin
                    wd_cnt_q <= wd_cnt_q + 8'h01;
                end
            end
        end
    end

    // Charge safety timer
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            safe_cnt_q             <= '0;
            half_q                 <= 1'b0;
            safety_timer_expired_q <= 1'b0;
        end else if (!charging_active || !timer_q[SAFE_EN_BIT]) begin
            safe_cnt_q             <= '0;
            half_q                 <= 1'b0;
            safety_timer_expired_q <= 1'b0;
        end else if (sec_tick && !safety_timer_expired_q) begin
            half_q <= !half_q;
            if (!(switch_q[HALF_BIT] && regulation_active) || half_q) begin
                if (safe_cnt_q + SAFE_W'(1) >= safe_limit(timer_q[SAFE_PER_LSB +: 2])) begin
                    safety_timer_expired_q <= 1'b1;
                end else begin
                    safe_cnt_q <= safe_cnt_q + SAFE_W'(1);
                end
            end
        end
    end

    // Ship mode battery switch control
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ship_cnt_q           <= 32'h0;
            battery_switch_off_q <= 1'b0;
        end else if (!switch_q[SHIP_BIT]) begin
            ship_cnt_q           <= 32'h0;
            battery_switch_off_q <= 1'b0;
        end else if (!switch_q[DLY_BIT]) begin
            battery_switch_off_q <= 1'b1;
        end else if (!battery_switch_off_q && sec_tick) begin
            if (ship_cnt_q + 32'h1 >= 32'(SHIP_DLY)) begin
                battery_switch_off_q <= 1'b1;
            end else begin
                ship_cnt_q <= ship_cnt_q + 32'h1;
            end
        end
    end

endmodule : cttbs_regs

// >>> dv/cttbs_checker.sv
/* Port assertions for cttbs_regs.
   Bound from the bench top file; one ref_clk domain. */
`timescale 1ns/100ps
module cttbs_checker
    import cttbs_pkg::*;
(
    // Clock and reset
    input wire logic       ref_clk,
    input wire logic       nrst,
    // Controls
    input wire logic       soft_reg_reset,
    input wire logic       pulse_control_enable,
    // Register outputs
    input wire logic       charge_term_enable_q,
    input wire logic       safety_timer_enable_q,
    input wire logic [1:0] safety_period_select_q,
    input wire logic [2:0] ir_comp_clamp_q,
    input wire logic [1:0] thermal_threshold_select_q,
    input wire logic       timer_half_speed_enable_q,
    input wire logic       system_reset_enable_q,
    input wire logic       pulse_raise_request_q,
    input wire logic [7:0] boost_control_q,
    input wire logic       watchdog_expired_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    rst_timer_a: assert property ($rose(nrst) |-> charge_term_enable_q &&
        safety_timer_enable_q && safety_period_select_q == 2'h2) else $error("timer not at POR");
    soft_boost_a: assert property (soft_reg_reset |=> boost_control_q == POR_BOOST)
        else $error("boost not reset");
    soft_comp_a: assert property (soft_reg_reset |=> ir_comp_clamp_q == 3'h0 &&
        thermal_threshold_select_q == 2'h3) else $error("comp not reset");
    soft_switch_a: assert property (soft_reg_reset |=> timer_half_speed_enable_q &&
        system_reset_enable_q) else $error("switch reg not reset");
    pulse_gate_a: assert property (!pulse_control_enable && !pulse_raise_request_q
        |=> !pulse_raise_request_q) else $error("pulse set while gated");
    wd_pulse_a: assert property (watchdog_expired_q |=> !watchdog_expired_q)
        else $error("expiry pulse too long");
    wd_restore_a: assert property (watchdog_expired_q |-> ##2
        thermal_threshold_select_q == 2'h3 && timer_half_speed_enable_q)
        else $error("expiry did not restore");
    wd_keep_a: assert property (watchdog_expired_q && !soft_reg_reset |-> ##2
        system_reset_enable_q == $past(system_reset_enable_q, 2))
        else $error("expiry touched reset enable");
endmodule : cttbs_checker

// >>> dv/cttbs_host.sv
/* Two-wire bus controller model with write and read tasks.
   The bench resolves the open-drain data wire with a pull-up. */
`timescale 1ns/100ps
module cttbs_host
    import cttbs_pkg::*;
(
    // Clock
    input  wire logic ref_clk,
    // Bus
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic ph();
        repeat (4) @(negedge ref_clk);
    endtask : ph
    task automatic bt(input logic b, output logic r);
        sda_drv = b;
        ph();
        scl = 1'b1;
        ph();
        r = sda;
        scl = 1'b0;
    endtask : bt
    task automatic start();
        sda_drv = 1'b1;
        ph();
        scl = 1'b1;
        ph();
        sda_drv = 1'b0;
        ph();
        scl = 1'b0;
    endtask : start
    task automatic stop();
        sda_drv = 1'b0;
        ph();
        scl = 1'b1;
        ph();
        sda_drv = 1'b1;
        ph();
    endtask : stop
    // Byte MSB first, then one acknowledge slot
    task automatic bx(input logic [7:0] v, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) bt(v[i], r[i]);
        bt(1'b1, a);
    endtask : bx
    task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic a0, a1, a2;
        start();
        bx({BUS_ADDR, 1'b0}, r, a0);
        bx(p, r, a1);
        bx(d, r, a2);
        stop();
        ok = !(a0 | a1 | a2);
    endtask : wr
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        logic a;
        start();
        bx({BUS_ADDR, 1'b0}, d, a);
        bx(p, d, a);
        start();
        bx({BUS_ADDR, 1'b1}, d, a);
        bx(8'hFF, d, a);
        stop();
    endtask : rd
endmodule : cttbs_host

// >>> dv/cttbs_regs_bench.sv
/* Self-checking bench for cttbs_regs with the bus controller model.
   Short second tick and ship delay keep the run brief. */
`timescale 1ns/100ps
module cttbs_regs_bench
    import cttbs_pkg::*;
;
    localparam int SEC_T = 20;
    localparam int SHIP_T = 3;
    logic ref_clk, nrst, scl, sda_drv, sda, sda_oe_q, ok;
    logic soft_reg_reset, watchdog_kick, charging_active, regulation_active;
    logic pulse_control_enable, pulse_sequence_done, charge_term_enable_q, status_pin_disable_q;
    logic safety_timer_enable_q, timer_half_speed_enable_q, system_reset_enable_q;
    logic pulse_raise_request_q, pulse_lower_request_q, battery_switch_off_q;
    logic watchdog_expired_q, safety_timer_expired_q;
    logic [1:0] safety_period_select_q, thermal_threshold_select_q;
    logic [2:0] ir_comp_resistance_q, ir_comp_clamp_q;
    logic [7:0] boost_control_q, d;
    int fails = 0, cmp_count = 0, cyc = 0, n;
    assign sda = sda_drv & ~sda_oe_q;
    cttbs_host u_cttbs_host (.ref_clk, .scl, .sda_drv, .sda);
    cttbs_regs #(.SEC_CYC(SEC_T), .SHIP_DLY(SHIP_T)) u_cttbs_regs (.ref_clk, .nrst,
        .scl_in(scl), .sda_in(sda), .sda_out_q(), .sda_oe_q, .soft_reg_reset, .watchdog_kick,
        .charging_active, .regulation_active, .pulse_control_enable, .pulse_sequence_done,
        .charge_term_enable_q, .status_pin_disable_q, .safety_timer_enable_q,
        .safety_period_select_q, .ir_comp_resistance_q, .ir_comp_clamp_q,
        .thermal_threshold_select_q, .timer_half_speed_enable_q, .system_reset_enable_q,
        .pulse_raise_request_q, .pulse_lower_request_q, .boost_control_q,
        .battery_switch_off_q, .watchdog_expired_q, .safety_timer_expired_q);
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    task automatic t_por();
        logic [7:0] e [5] = '{POR_TIMER, POR_COMP, POR_SWITCH, POR_BOOST, 8'h00};
        for (int i = 0; i < 5; i++) begin
            u_cttbs_host.rd(ADDR_TIMER + 8'(i), d);
            chk(d, e[i]);
        end
    endtask : t_por
    task automatic t_fields();
        watchdog_kick = 1'b1;
        @(negedge ref_clk) watchdog_kick = 1'b0;
        u_cttbs_host.wr(ADDR_TIMER, 8'h42, ok);
        chk(8'(ok), 8'h01);
        chk({3'h0, charge_term_enable_q, status_pin_disable_q, safety_timer_enable_q,
            safety_period_select_q}, 8'h09);
        u_cttbs_host.rd(ADDR_TIMER, d);
        chk(d, 8'h42);
        u_cttbs_host.wr(ADDR_COMP, 8'hA9, ok);
        chk({ir_comp_resistance_q, ir_comp_clamp_q,
            thermal_threshold_select_q}, 8'hA9);
        u_cttbs_host.wr(ADDR_BOOST, 8'h5A, ok);
        chk(boost_control_q, 8'h5A);
    endtask : t_fields
    task automatic t_pulse();
        u_cttbs_host.wr(ADDR_SWITCH, 8'h47, ok);
        chk({pulse_raise_request_q, pulse_lower_request_q}, 8'h0);
        pulse_control_enable = 1'b1;
        u_cttbs_host.wr(ADDR_SWITCH, 8'h47, ok);
        chk({pulse_raise_request_q, pulse_lower_request_q}, 8'h3);
        pulse_sequence_done = 1'b1;
        @(negedge ref_clk) pulse_sequence_done = 1'b0;
        @(negedge ref_clk);
        chk({pulse_raise_request_q, pulse_lower_request_q}, 8'h0);
    endtask : t_pulse
    task automatic t_ship();
        u_cttbs_host.wr(ADDR_SWITCH, 8'h64, ok);
        chk(battery_switch_off_q, 1'b1);
        u_cttbs_host.wr(ADDR_SWITCH, 8'h44, ok);
        chk(battery_switch_off_q, 1'b0);
        u_cttbs_host.wr(ADDR_SWITCH, 8'h28, ok);
        chk({5'h0, battery_switch_off_q,
            timer_half_speed_enable_q, system_reset_enable_q}, 8'h00);
        repeat ((SHIP_T + 1) * SEC_T + 4) @(negedge ref_clk);
        chk(battery_switch_off_q, 1'b1);
    endtask : t_ship
    task automatic t_wdog();
        u_cttbs_host.wr(ADDR_TIMER, POR_TIMER, ok);
        n = 0;
        while (watchdog_expired_q !== 1'b1 && n < 41 * SEC_T) begin
            @(negedge ref_clk);
            n++;
        end
        chk(8'(n >= 39 * SEC_T - 18 && n <= 40 * SEC_T), 8'h1);
        repeat (2) @(negedge ref_clk);
        chk({ir_comp_resistance_q, ir_comp_clamp_q,
            thermal_threshold_select_q}, POR_COMP);
        u_cttbs_host.rd(ADDR_SWITCH, d);
        chk(d, 8'h68);
        chk(battery_switch_off_q, 1'b1);
        soft_reg_reset = 1'b1;
        @(negedge ref_clk) soft_reg_reset = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk({6'h0, battery_switch_off_q, system_reset_enable_q}, 8'h01);
        chk(boost_control_q, POR_BOOST);
    endtask : t_wdog
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        {nrst, soft_reg_reset, watchdog_kick, charging_active, regulation_active} = '0;
        {pulse_control_enable, pulse_sequence_done} = '0;
        repeat (6) @(negedge ref_clk);
        nrst = 1'b1;
        repeat (2) @(negedge ref_clk);
        t_por();
        t_fields();
        t_pulse();
        t_ship();
        t_wdog();
        close_out();
    end
endmodule : cttbs_regs_bench
bind cttbs_regs cttbs_checker u_cttbs_checker (.ref_clk, .nrst, .soft_reg_reset,
    .pulse_control_enable, .charge_term_enable_q, .safety_timer_enable_q,
    .safety_period_select_q, .ir_comp_clamp_q, .thermal_threshold_select_q,
    .timer_half_speed_enable_q, .system_reset_enable_q, .pulse_raise_request_q,
    .boost_control_q, .watchdog_expired_q);
